// [ptc_trigger_timestamp.sv]
//
// Behaviour
// RQ1 - Index pointers select unit for each access.
// RQ2 - Pin output combinational or flopped per select.
// RQ3 - Read-only bit shows indexed pin input level.
// RQ4 - Direction bit one makes pin capture input.
// RQ5 - Capture interrupt status only when enabled.
// RQ6 - Active flag while armed and error-free.
// RQ7 - Enable arms unit, self-clears on firing.
// RQ8 - Software enables only cascade chain head; this code has no cascade, each unit is armed by its own enable write.
// RQ9 - Trigger soft reset restores defaults, halts chain; this code has no chain, the reset clears only the indexed unit.
// RQ10 - Capture enable write one clears count.
// RQ11 - Capture enable write zero clears flags.
// RQ12 - Capture soft reset restores unit defaults.
// RQ13 - Thirty-bit target nanoseconds, upper bits zero.
// RQ14 - Thirty-two-bit target seconds compared with time.
// RQ15 - Late target with notify sets error, interrupt.
// RQ16 - Notify bit gates done and error reporting.
// RQ17 - Fire-now bit fires late target at once.
// RQ18 - Soft reset bits act as self-clearing pulses.
`timescale 1ns/1ns
`default_nettype none
module ptc_trigger_timestamp (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [31:0] SYS_TIME_SEC,
  input wire logic [29:0] SYS_TIME_NS,
  input wire logic [1:0] PIN_IN,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE_N,
  output logic IRQ
);
  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access takes effect.
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic [31:0] cs_word;
  wire req = AVS_READ | AVS_WRITE;
  wire wr = AVS_WRITE & ack_ff;
  wire wr_idx = wr & (AVS_ADDRESS == ptc_pkg::OFS_INDEX);
  wire cs_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_CTRL_STAT);
  wire ns_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_TGT_NS);
  wire sec_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_TGT_SEC);
  wire cfg_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_FIRE_CFG);
  wire clr_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_IRQ_CLR);
  wire ien_wr = wr & (AVS_ADDRESS == ptc_pkg::OFS_IRQ_EN);
  assign AVS_WAITREQUEST = req & ~ack_ff;
  assign AVS_READDATA = rdata_ff;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_ff <= 1'b0;
      rdata_ff <= ptc_pkg::RST_WORD;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (AVS_READ & ~ack_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Unit index pointers.
  logic [1:0] fire_ptr_ff;
  logic cap_ptr_ff;
  logic pin_ptr_ff;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fire_ptr_ff <= 2'h0;
      cap_ptr_ff <= 1'b0;
      pin_ptr_ff <= 1'b0;
    end else if (wr_idx) begin
      fire_ptr_ff <= AVS_WRITEDATA[ptc_pkg::IDX_FIRE_LSB +: 2]; // RQ1
      cap_ptr_ff <= AVS_WRITEDATA[ptc_pkg::IDX_CAP_BIT]; // RQ1
      pin_ptr_ff <= AVS_WRITEDATA[ptc_pkg::IDX_PIN_BIT]; // RQ1
    end
  end
  wire fire_ok = fire_ptr_ff < 2'(ptc_pkg::NUM_FIRE);

  //////////////////////////////////////////////////////////////////////////////
  // Trigger output units.
  logic [2:0] fire;
  logic [2:0] en_ff;
  logic [2:0] err_ff;
  logic [2:0] late_arm;
  logic [2:0] err_drop;
  logic [2:0] notify_ff;
  logic [2:0] now_ff;
  logic [29:0] tns_ff [3];
  logic [31:0] tsec_ff [3];
  wire [61:0] sys_time = {SYS_TIME_SEC, SYS_TIME_NS};

  genvar i;
  for (i = 0; i < ptc_pkg::NUM_FIRE; i++) begin : g_fire
    wire sel = fire_ptr_ff == 2'(i);
    wire cs_sel = cs_wr & sel;
    wire rst = cs_sel & AVS_WRITEDATA[ptc_pkg::CS_FIRE_RST];
    wire reached = sys_time >= {tsec_ff[i], tns_ff[i]}; // RQ14
    wire arm = cs_sel & AVS_WRITEDATA[ptc_pkg::CS_FIRE_EN] & ~en_ff[i];
    assign late_arm[i] = arm & reached & ~now_ff[i] & ~rst;
    assign err_drop[i] = cs_sel & ~AVS_WRITEDATA[ptc_pkg::CS_FIRE_EN]; // RQ15
    assign fire[i] = en_ff[i] & ~err_ff[i] & reached; // RQ17
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
        en_ff[i] <= 1'b0;
        err_ff[i] <= 1'b0;
        notify_ff[i] <= 1'b0;
        now_ff[i] <= 1'b0;
        tns_ff[i] <= 30'h0000_0000;
        tsec_ff[i] <= ptc_pkg::RST_WORD;
      end else if (rst) begin
        en_ff[i] <= 1'b0; // RQ9
        err_ff[i] <= 1'b0;
        notify_ff[i] <= 1'b0;
        now_ff[i] <= 1'b0;
        tns_ff[i] <= 30'h0000_0000;
        tsec_ff[i] <= ptc_pkg::RST_WORD;
      end else begin
        if (cs_sel) begin
          en_ff[i] <= AVS_WRITEDATA[ptc_pkg::CS_FIRE_EN]; // RQ7
        end else if (fire[i]) begin
          en_ff[i] <= 1'b0; // RQ7
        end
        if (cs_sel & ~AVS_WRITEDATA[ptc_pkg::CS_FIRE_EN]) begin
          err_ff[i] <= 1'b0; // RQ15
        end else if (late_arm[i]) begin
          err_ff[i] <= 1'b1; // RQ15
        end
        if (ns_wr & sel) begin
          tns_ff[i] <= AVS_WRITEDATA[29:0]; // RQ13
        end
        if (sec_wr & sel) begin
          tsec_ff[i] <= AVS_WRITEDATA; // RQ14
        end
        if (cfg_wr & sel) begin
          notify_ff[i] <= AVS_WRITEDATA[ptc_pkg::CFG_NOTIFY];
          now_ff[i] <= AVS_WRITEDATA[ptc_pkg::CFG_NOW];
        end
      end
    end
    chk_fire_clears_en: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ7
      fire[i] && !cs_sel |=> !en_ff[i])
      else $error("Enable did not self-clear after firing.");
    chk_active_drops: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ6
      late_arm[i] |=> en_ff[i] && !(en_ff[i] && !err_ff[i]) && !fire[i])
      else $error("Active flag or firing despite late target.");
    chk_now_fires: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ17
      arm && reached && now_ff[i] && !rst |=> fire[i])
      else $error("Fire-now unit did not fire next cycle.");
    chk_fire_reset: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
      rst |=> !en_ff[i] && tns_ff[i] == 30'h0000_0000 && !err_ff[i])
      else $error("Trigger soft reset left state behind.");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins: pin n is driven by trigger unit n and feeds capture unit n.
  logic [1:0] dir_ff;
  logic [1:0] out_sel_ff;
  logic [1:0] pin_q_ff;
  logic [1:0] pin_prev_ff;
  wire pin_cs_wr = cs_wr;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dir_ff <= 2'h0;
      out_sel_ff <= 2'h0;
      pin_q_ff <= 2'h0;
      pin_prev_ff <= 2'h0;
    end else begin
      pin_q_ff <= fire[1:0];
      pin_prev_ff <= PIN_IN;
      if (pin_cs_wr) begin
        dir_ff[pin_ptr_ff] <= AVS_WRITEDATA[ptc_pkg::CS_DIR]; // RQ4
        out_sel_ff[pin_ptr_ff] <= AVS_WRITEDATA[ptc_pkg::CS_OUT_SEL];
      end
    end
  end
  assign PIN_OUT = (out_sel_ff & fire[1:0]) | (~out_sel_ff & pin_q_ff); // RQ2
  assign PIN_OE_N = dir_ff; // RQ4
  chk_pin_flopped: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ2
    !out_sel_ff[0] |-> PIN_OUT[0] == $past(fire[0]))
    else $error("Flopped pin path does not lag the trigger by one cycle.");

  //////////////////////////////////////////////////////////////////////////////
  // Timestamp capture units: rising edges on input pins are counted.
  logic [1:0] cap_en_ff;
  logic [1:0] cap_ie_ff;
  logic [1:0] rdy_ff;
  logic [1:0] ovf_ff;
  logic [1:0] cap_ev;
  logic [3:0] cnt_ff [2];
  for (i = 0; i < ptc_pkg::NUM_CAP; i++) begin : g_cap
    wire cw = cs_wr & (cap_ptr_ff == 1'(i));
    wire crst = cw & AVS_WRITEDATA[ptc_pkg::CS_CAP_RST];
    assign cap_ev[i] = cap_en_ff[i] & dir_ff[i] & PIN_IN[i] & ~pin_prev_ff[i];
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
        cap_en_ff[i] <= 1'b0;
        cap_ie_ff[i] <= 1'b0;
        rdy_ff[i] <= 1'b0;
        ovf_ff[i] <= 1'b0;
        cnt_ff[i] <= 4'h0;
      end else if (crst) begin
        cap_en_ff[i] <= 1'b0; // RQ12
        cap_ie_ff[i] <= 1'b0;
        rdy_ff[i] <= 1'b0;
        ovf_ff[i] <= 1'b0;
        cnt_ff[i] <= 4'h0;
      end else if (cw) begin
        cap_en_ff[i] <= AVS_WRITEDATA[ptc_pkg::CS_CAP_EN];
        cap_ie_ff[i] <= AVS_WRITEDATA[ptc_pkg::CS_CAP_IRQ_EN];
        if (AVS_WRITEDATA[ptc_pkg::CS_CAP_EN]) begin
          cnt_ff[i] <= 4'h0; // RQ10
        end else begin
          rdy_ff[i] <= 1'b0; // RQ11
          ovf_ff[i] <= 1'b0; // RQ11
        end
      end else if (cap_ev[i]) begin
        rdy_ff[i] <= 1'b1;
        if (cnt_ff[i] == ptc_pkg::CNT_MAX) begin
          ovf_ff[i] <= 1'b1;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 4'h1;
        end
      end
    end
    chk_cap_enable: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ10
      cw && !crst && AVS_WRITEDATA[ptc_pkg::CS_CAP_EN] |=> cap_en_ff[i] && cnt_ff[i] == 4'h0)
      else $error("Capture enable did not clear the event count.");
    chk_cap_disable: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ11
      cw && !AVS_WRITEDATA[ptc_pkg::CS_CAP_EN] |=> !rdy_ff[i] && !ovf_ff[i] && !cap_en_ff[i])
      else $error("Capture disable left flags set.");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable; a set beats a same-cycle clear.
  logic [31:0] ist_ff;
  logic [31:0] ien_ff;
  logic [31:0] ist_set;
  logic [31:0] ist_clr;
  // Disarming a unit also drops its reported error status.
  always_comb begin
    ist_clr = clr_wr ? AVS_WRITEDATA : ptc_pkg::RST_WORD;
    ist_clr[ptc_pkg::IRQ_ERR_LSB +: 3] = ist_clr[ptc_pkg::IRQ_ERR_LSB +: 3] | err_drop; // RQ15
    ist_set = ptc_pkg::RST_WORD;
    ist_set[ptc_pkg::IRQ_DONE_LSB +: 3] = fire & notify_ff; // RQ16
    ist_set[ptc_pkg::IRQ_ERR_LSB +: 3] = late_arm & notify_ff; // RQ15
    ist_set[ptc_pkg::IRQ_CAP_LSB +: 2] = cap_ev & cap_ie_ff; // RQ5
  end
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ist_ff <= ptc_pkg::RST_WORD;
      ien_ff <= ptc_pkg::RST_WORD;
    end else begin
      ist_ff <= ist_set | (ist_ff & ~ist_clr);
      if (ien_wr) begin
        ien_ff <= AVS_WRITEDATA;
      end
    end
  end
  assign IRQ = |(ist_ff & ien_ff);
  chk_notify_gate: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ16
    fire[0] && !notify_ff[0] && !ist_ff[ptc_pkg::IRQ_DONE_LSB] |=>
      !ist_ff[ptc_pkg::IRQ_DONE_LSB])
    else $error("Done status raised with notify off.");
  chk_cap_irq: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ5
    cap_ev[0] && !cap_ie_ff[0] && !ist_ff[ptc_pkg::IRQ_CAP_LSB] |=>
      !ist_ff[ptc_pkg::IRQ_CAP_LSB])
    else $error("Capture status raised with interrupt disabled.");
  chk_bus_answer: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Bus access held longer than one wait cycle.");

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; soft reset bits always read back as zero.
  always_comb begin
    cs_word = ptc_pkg::RST_WORD; // RQ18
    cs_word[ptc_pkg::CS_OUT_SEL] = out_sel_ff[pin_ptr_ff];
    cs_word[ptc_pkg::CS_PIN_IN] = PIN_IN[pin_ptr_ff]; // RQ3
    cs_word[ptc_pkg::CS_DIR] = dir_ff[pin_ptr_ff];
    cs_word[ptc_pkg::CS_CAP_IRQ_EN] = cap_ie_ff[cap_ptr_ff];
    cs_word[ptc_pkg::CS_CAP_EN] = cap_en_ff[cap_ptr_ff];
    if (fire_ok) begin
      cs_word[ptc_pkg::CS_ACTIVE] = en_ff[fire_ptr_ff] & ~err_ff[fire_ptr_ff]; // RQ6
      cs_word[ptc_pkg::CS_FIRE_EN] = en_ff[fire_ptr_ff];
    end
    rd_mux = ptc_pkg::RST_WORD;
    case (AVS_ADDRESS)
      ptc_pkg::OFS_INDEX: begin
        rd_mux[ptc_pkg::IDX_FIRE_LSB +: 2] = fire_ptr_ff;
        rd_mux[ptc_pkg::IDX_CAP_BIT] = cap_ptr_ff;
        rd_mux[ptc_pkg::IDX_PIN_BIT] = pin_ptr_ff;
      end
      ptc_pkg::OFS_CTRL_STAT: rd_mux = cs_word;
      ptc_pkg::OFS_TGT_NS: rd_mux = fire_ok ? {2'h0, tns_ff[fire_ptr_ff]} : 32'h0; // RQ13
      ptc_pkg::OFS_TGT_SEC: rd_mux = fire_ok ? tsec_ff[fire_ptr_ff] : 32'h0;
      ptc_pkg::OFS_FIRE_CFG: begin
        if (fire_ok) begin
          rd_mux[ptc_pkg::CFG_NOTIFY] = notify_ff[fire_ptr_ff];
          rd_mux[ptc_pkg::CFG_NOW] = now_ff[fire_ptr_ff];
        end
      end
      ptc_pkg::OFS_IRQ_STAT: rd_mux = ist_ff;
      ptc_pkg::OFS_IRQ_EN: rd_mux = ien_ff;
      default: rd_mux = ptc_pkg::RST_WORD;
    endcase
  end
endmodule
`default_nettype wire

// [ptc_pkg.sv]
package ptc_pkg;
  localparam logic [11:0] OFS_INDEX = 12'h520;
  localparam logic [11:0] OFS_CTRL_STAT = 12'h52C;
  localparam logic [11:0] OFS_TGT_NS = 12'h530;
  localparam logic [11:0] OFS_TGT_SEC = 12'h534;
  localparam logic [11:0] OFS_FIRE_CFG = 12'h538;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h540;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h544;
  localparam logic [11:0] OFS_IRQ_EN = 12'h548;
  localparam int NUM_FIRE = 3;
  localparam int NUM_CAP = 2;
  localparam int NUM_PIN = 2;
  localparam int NS_W = 30;
  localparam int CNT_W = 4;
  localparam int IDX_FIRE_LSB = 0;
  localparam int IDX_CAP_BIT = 8;
  localparam int IDX_PIN_BIT = 16;
  localparam int CS_OUT_SEL = 8;
  localparam int CS_PIN_IN = 7;
  localparam int CS_DIR = 6;
  localparam int CS_CAP_IRQ_EN = 5;
  localparam int CS_ACTIVE = 4;
  localparam int CS_FIRE_EN = 3;
  localparam int CS_FIRE_RST = 2;
  localparam int CS_CAP_EN = 1;
  localparam int CS_CAP_RST = 0;
  localparam int CFG_NOTIFY = 24;
  localparam int CFG_NOW = 25;
  localparam int IRQ_DONE_LSB = 0;
  localparam int IRQ_ERR_LSB = 16;
  localparam int IRQ_CAP_LSB = 24;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
endpackage

// [ptc_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ptc_pin_model (
  input wire logic CLOCK,
  input wire logic [1:0] ev_level,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] pin_in
);
  logic [1:0] drv_ff;
  always_ff @(posedge CLOCK) begin
    drv_ff <= ev_level;
  end
  // A pin that the device drives reads back its own output level.
  assign pin_in = (pin_oe_n & drv_ff) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// [ptc_trigger_timestamp_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module ptc_trigger_timestamp_ctrl_tb;
  logic CLOCK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
  logic [11:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, SYS_TIME_SEC, rd;
  logic [31:0] ns_a [3];
  logic [31:0] s_a [3];
  logic [29:0] SYS_TIME_NS;
  logic [1:0] PIN_IN, PIN_OUT, PIN_OE_N, ev_level;
  int errors, checks_done, seed, u, k;
  ptc_trigger_timestamp dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SYS_TIME_SEC(SYS_TIME_SEC), .SYS_TIME_NS(SYS_TIME_NS), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .IRQ(IRQ));
  ptc_pin_model pins (.CLOCK(CLOCK), .ev_level(ev_level), .pin_out(PIN_OUT),
    .pin_oe_n(PIN_OE_N), .pin_in(PIN_IN));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task finish_test;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The request is held until the rising edge that samples waitrequest low.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (AVS_WAITREQUEST !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task idx(input int t, input int c, input int p);
    wr(ptc_pkg::OFS_INDEX, {15'h0, p[0], 7'h0, c[0], 6'h0, t[1:0]});
  endtask
  function automatic logic [31:0] exp_ns(input logic [31:0] d);
    return {2'h0, d[29:0]};
  endfunction
  // A fired unit shows a single high cycle on its pin; the flopped pin lags one cycle.
  task fire_pulse(input int p);
    k = 0;
    do begin
      @(negedge CLOCK);
      k++;
    end while (PIN_OUT[p] !== 1'b1 && k < 20);
    chk("fire seen", 32'h1, {31'h0, PIN_OUT[p]});
    chk("fire lag", 2 - p, k);
    @(negedge CLOCK);
    chk("fire width", 32'h0, {31'h0, PIN_OUT[p]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    finish_test;
  end
  initial begin
    seed = 36881;
    SYS_RST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 12'h000;
    AVS_WRITEDATA = 32'h0;
    SYS_TIME_SEC = 32'h10;
    SYS_TIME_NS = 30'h100;
    ev_level = 2'h0;
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rdc("ctrl reset", ptc_pkg::OFS_CTRL_STAT, 32'hFFFFFFFF, 32'h0);
    rdc("ns reset", ptc_pkg::OFS_TGT_NS, 32'hFFFFFFFF, 32'h0);
    rdc("sec reset", ptc_pkg::OFS_TGT_SEC, 32'hFFFFFFFF, 32'h0);
    chk("oe reset", 32'h0, {30'h0, PIN_OE_N});
    wr(12'h5F0, $random(seed));
    rdc("unmapped", 12'h5F0, 32'hFFFFFFFF, 32'h0);
    for (u = 0; u < 3; u++) begin
      idx(u, 0, 0);
      ns_a[u] = $random(seed);
      s_a[u] = $random(seed);
      wr(ptc_pkg::OFS_TGT_NS, ns_a[u]);
      wr(ptc_pkg::OFS_TGT_SEC, s_a[u]);
    end
    for (u = 0; u < 3; u++) begin
      idx(u, 0, 0);
      rdc("ns bank", ptc_pkg::OFS_TGT_NS, 32'hFFFFFFFF, exp_ns(ns_a[u]));
      rdc("sec bank", ptc_pkg::OFS_TGT_SEC, 32'hFFFFFFFF, s_a[u]);
    end
    idx(3, 0, 0);
    rdc("ns idx3", ptc_pkg::OFS_TGT_NS, 32'hFFFFFFFF, 32'h0);
    wr(ptc_pkg::OFS_IRQ_EN, 32'h0307_0007);
    for (u = 0; u < 2; u++) begin
      idx(u, 0, u);
      wr(ptc_pkg::OFS_FIRE_CFG, 32'h0100_0000);
      wr(ptc_pkg::OFS_TGT_NS, 32'h200);
      wr(ptc_pkg::OFS_TGT_SEC, 32'h10);
      wr(ptc_pkg::OFS_CTRL_STAT, 32'h8 | (u << 8));
      rdc("armed", ptc_pkg::OFS_CTRL_STAT, 32'hFFFFFFFF, 32'h18 | (u << 8));
      SYS_TIME_NS <= 30'h200 + 30'($unsigned($random(seed)) % 16);
      fire_pulse(u);
      rdc("fired", ptc_pkg::OFS_CTRL_STAT, 32'hFFFFFFFF, u << 8);
      rdc("done", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 1 << u);
      chk("irq done", 32'h1, {31'h0, IRQ});
      SYS_TIME_NS <= 30'h100;
      wr(ptc_pkg::OFS_IRQ_CLR, 1 << u);
      @(negedge CLOCK);
      chk("irq clr", 32'h0, {31'h0, IRQ});
    end
    idx(2, 0, 0);
    wr(ptc_pkg::OFS_FIRE_CFG, 32'h0100_0000);
    wr(ptc_pkg::OFS_TGT_SEC, 32'h10);
    wr(ptc_pkg::OFS_TGT_NS, 32'h50);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h8);
    rdc("late active", ptc_pkg::OFS_CTRL_STAT, 32'h10, 32'h0);
    rdc("late err", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0004_0000);
    chk("irq err", 32'h1, {31'h0, IRQ});
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h0);
    rdc("err clr", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    wr(ptc_pkg::OFS_FIRE_CFG, 32'h0300_0000);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h8);
    rdc("now done", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h4);
    wr(ptc_pkg::OFS_IRQ_CLR, 32'h4);
    wr(ptc_pkg::OFS_FIRE_CFG, 32'h0200_0000);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h8);
    rdc("quiet en", ptc_pkg::OFS_CTRL_STAT, 32'h18, 32'h0);
    rdc("quiet stat", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    wr(ptc_pkg::OFS_FIRE_CFG, 32'h0100_0000);
    wr(ptc_pkg::OFS_TGT_NS, 32'h3FFF_FFFF);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h8);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h4);
    rdc("srst ctrl", ptc_pkg::OFS_CTRL_STAT, 32'h1C, 32'h0);
    rdc("srst ns", ptc_pkg::OFS_TGT_NS, 32'hFFFFFFFF, 32'h0);
    rdc("srst cfg", ptc_pkg::OFS_FIRE_CFG, 32'hFFFFFFFF, 32'h0);
    idx(0, 1, 1);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h62);
    ev_level <= 2'h2;
    @(negedge CLOCK);
    chk("oe input", 32'h1, {31'h0, PIN_OE_N[1]});
    repeat (2 + $unsigned($random(seed)) % 4) @(posedge CLOCK);
    rdc("pin in hi", ptc_pkg::OFS_CTRL_STAT, 32'hFFFFFFFF, 32'hE2);
    rdc("cap stat", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0200_0000);
    chk("irq cap", 32'h1, {31'h0, IRQ});
    wr(ptc_pkg::OFS_IRQ_EN, 32'h0);
    ev_level <= 2'h0;
    @(negedge CLOCK);
    chk("irq mask", 32'h0, {31'h0, IRQ});
    wr(ptc_pkg::OFS_IRQ_CLR, 32'h0200_0000);
    rdc("pin in lo", ptc_pkg::OFS_CTRL_STAT, 32'h80, 32'h0);
    rdc("cap clr", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    wr(ptc_pkg::OFS_CTRL_STAT, 32'h42);
    ev_level <= 2'h2;
    repeat (3) @(posedge CLOCK);
    rdc("cap no irq", ptc_pkg::OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
